// >>> logic/anpfx_top.sv
// Next page and 100BASE-X auxiliary control registers behind the serial
// management port. Assumes mdc/mdio pins and negotiation strobes are
// synchronous to core_clk; the pad merges mdio_out under mdio_oe_n.
`timescale 1ns/1ps

module anpfx_top (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  phy_addr,                          // Strapped address
  input  wire logic        mdc,                               // Management clock pin
  input  wire logic        mdio_in,                           // Management data in
  output logic             mdio_out,                          // Management data out
  output logic             mdio_oe_n,                         // Low while driving
  input  wire logic        an_page_sent,                      // Next page sent and acked
  input  wire logic        an_restart,                        // Negotiation restarted
  input  wire logic        an_rx_page_valid,                  // Partner page received
  input  wire logic [15:0] an_rx_page,                        // Partner page word
  output logic [15:0]      np_tx_page,                        // Page for the arbiter
  output logic             np_tx_ready,                       // Page waiting
  output logic             next_page_able,                    // Ability status bit
  output logic             differential_transmit_output_oe_n, // High: transmitter off
  output logic             bypass_4b5b,
  output logic             bypass_scrambler,
  output logic             bypass_nrzi,
  output logic             bypass_symbol_align,
  output logic             blw_correction_off,
  output logic             far_end_fault_signalling,          // Fault mechanism enable
  output logic             ext_rx_fifo,
  output logic             rmii_oob_en
);
  anpfx_regbus_if bus ();                    // Frame engine to register bank

  logic [15:0] out_np_r, out_np_nxt;         // Outgoing page, toggle held apart
  logic [15:0] partner_r, partner_nxt;       // Received partner page
  logic [15:0] aux_r, aux_nxt;               // Auxiliary control
  logic [15:0] tx_page_r, tx_page_nxt;       // Registered page for the arbiter
  logic        tx_ready_r;                   // Registered ready, aligned with page
  logic        np_able_r;                    // Ability flag flop
  logic        arb_ready;                    // Handshake flag from the arbiter
  logic        arb_toggle;                   // Toggle from the arbiter
  logic        wr_out_np;                    // Write strobe to 07h
  logic        wr_aux;                       // Write strobe to 10h
  logic [15:0] rd_mux;                       // Read data for the frame engine

  // Address compare shared by write decode and read select
  function automatic logic reg_is(input logic [4:0] a, input logic [4:0] r);
    reg_is = (a == r);
  endfunction

  // The engine owns the pin timing; this module only sees one-cycle
  // write strobes and a held address, so register logic stays simple.
  // Serial frame engine
  anpfx_mdio_frame u_frame (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .phy_addr  (phy_addr),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .bus       (bus.frame)
  );

  // Only the two writable registers get a strobe; a frame aimed at the
  // expansion or partner address changes nothing here.
  // Write decode; partner page has no write path at all
  assign wr_out_np = bus.wr_stb & reg_is(bus.addr, anpfx_pkg::REG_OUT_NP);
  assign wr_aux    = bus.wr_stb & reg_is(bus.addr, anpfx_pkg::REG_AUX);

  // Next page sequencing lives apart so its flags have a single owner
  anpfx_np_arbiter u_arb (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .load       (wr_out_np),
    .page_sent  (an_page_sent),
    .an_restart (an_restart),
    .ready      (arb_ready),
    .toggle     (arb_toggle)
  );

  // Each register keeps its value unless its own strobe fires; the
  // partner page is loaded only from the negotiation side.
  // Register next values
  always_comb begin
    out_np_nxt  = out_np_r;
    partner_nxt = partner_r;
    aux_nxt     = aux_r;
    // Only documented fields are stored; toggle and reserved bits stay zero
    if (wr_out_np) begin
      out_np_nxt = bus.wdata & anpfx_pkg::NP_WR_MASK;
    end
    // Manager must not rely on reserved bits surviving a write
    if (wr_aux) begin
      aux_nxt = bus.wdata & anpfx_pkg::AUX_WR_MASK;
    end
    // Capture the partner word with bit 14 cleared by PARTNER_MASK
    if (an_rx_page_valid) begin
      partner_nxt = an_rx_page & anpfx_pkg::PARTNER_MASK;
    end
    // Page word presented to negotiation carries the live toggle
    tx_page_nxt = out_np_r;
    tx_page_nxt[anpfx_pkg::NP_TOGGLE_BIT] = arb_toggle;
  end

  // Reset gives a message page with code 1 and every control bit clear,
  // so the transmitter starts enabled with normal coding.
  // Register storage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_np_r   <= anpfx_pkg::OUT_NP_RESET;
      partner_r  <= anpfx_pkg::PARTNER_RESET;
      aux_r      <= anpfx_pkg::AUX_RESET;
      tx_page_r  <= anpfx_pkg::OUT_NP_RESET;
      tx_ready_r <= 1'b0;
      np_able_r  <= 1'b0;
    end else begin
      out_np_r   <= out_np_nxt;
      partner_r  <= partner_nxt;
      aux_r      <= aux_nxt;
      tx_page_r  <= tx_page_nxt;
      tx_ready_r <= arb_ready;
      np_able_r  <= 1'b1;
    end
  end

  // The read word follows the held address; the engine latches it on the
  // first turnaround rise, one mdc period before the first bit shifts out.
  // Read select; unmapped addresses answer zero
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_is(bus.addr, anpfx_pkg::REG_OUT_NP)) begin
      rd_mux = out_np_r;
      rd_mux[anpfx_pkg::NP_TOGGLE_BIT] = arb_toggle;
    end else if (reg_is(bus.addr, anpfx_pkg::REG_PARTNER_NP)) begin
      rd_mux = partner_r;
    end else if (reg_is(bus.addr, anpfx_pkg::REG_AUX)) begin
      rd_mux = aux_r;
    end else if (reg_is(bus.addr, anpfx_pkg::REG_AN_EXP)) begin
      rd_mux = anpfx_pkg::AN_EXP_VALUE;
    end
  end
  assign bus.rdata = rd_mux;

  // Every control output is a flop bit, so no decode glitch can reach
  // the coding stages while a write lands.
  // Control fields straight from the auxiliary register
  assign differential_transmit_output_oe_n = aux_r[anpfx_pkg::AUX_TX_DIS_BIT];
  assign bypass_4b5b              = aux_r[anpfx_pkg::AUX_BYP_4B5B_BIT];
  assign bypass_scrambler         = aux_r[anpfx_pkg::AUX_BYP_SCR_BIT];
  assign bypass_nrzi              = aux_r[anpfx_pkg::AUX_BYP_NRZI_BIT];
  assign bypass_symbol_align      = aux_r[anpfx_pkg::AUX_BYP_ALN_BIT];
  assign blw_correction_off       = aux_r[anpfx_pkg::AUX_BLW_OFF_BIT];
  assign far_end_fault_signalling = aux_r[anpfx_pkg::AUX_FEF_BIT];
  assign ext_rx_fifo              = aux_r[anpfx_pkg::AUX_EXT_FIFO_BIT];
  assign rmii_oob_en              = aux_r[anpfx_pkg::AUX_OOB_BIT];

  // Page and ready are both one flop behind the arbiter, so they stay aligned
  assign np_tx_page     = tx_page_r;
  assign np_tx_ready    = tx_ready_r;
  assign next_page_able = np_able_r;

  // Assertions watch only what this module and its children drive;
  // the negotiation inputs are taken as given.
  // Checks on the register bank
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_np_write;
    wr_out_np && !an_restart;
  endsequence

  sequence s_page_out;
    an_page_sent && arb_ready && !wr_out_np && !an_restart;
  endsequence

  // Restart with no write in the same cycle
  sequence s_restart;
    an_restart && !wr_out_np;
  endsequence

  // Write lands in the stored fields
  a_np_fields_write: assert property (wr_out_np |=>
    (out_np_r == ($past(bus.wdata) & anpfx_pkg::NP_WR_MASK)))
    else $error("outgoing page fields not stored");

  // Ready rises after a write and is visible one cycle later at the port
  a_np_ready_set: assert property (s_np_write |=> arb_ready ##1 np_tx_ready)
    else $error("written page not marked ready");

  // Each sent page with no same-cycle write or restart flips the toggle and clears ready
  a_toggle_flip: assert property (s_page_out |=>
    (arb_toggle != $past(arb_toggle)) && !arb_ready)
    else $error("toggle did not alternate on send");

  // Toggle never follows software writes
  a_toggle_ro: assert property (wr_out_np && !an_page_sent && !an_restart |=>
    $stable(arb_toggle))
    else $error("toggle changed by write");

  // Port page carries the toggle one cycle later
  a_tx_page_tog: assert property (##1 np_tx_page[anpfx_pkg::NP_TOGGLE_BIT] ==
    $past(arb_toggle))
    else $error("page toggle mismatch");

  // Partner page captured without bit 14, never written by software
  a_partner_cap: assert property (an_rx_page_valid |=>
    partner_r == ($past(an_rx_page) & anpfx_pkg::PARTNER_MASK))
    else $error("partner page not captured");

  a_partner_ro: assert property (!an_rx_page_valid |=> $stable(partner_r))
    else $error("partner page changed without receive");

  // Aux write reaches the control outputs in one cycle
  a_aux_tx_dis: assert property (wr_aux |=>
    differential_transmit_output_oe_n == $past(bus.wdata[anpfx_pkg::AUX_TX_DIS_BIT]))
    else $error("transmit disable not applied");

  a_aux_bypass: assert property (wr_aux |=>
    {bypass_4b5b, bypass_scrambler, bypass_nrzi, bypass_symbol_align,
     blw_correction_off, far_end_fault_signalling} == $past(bus.wdata[10:5]))
    else $error("bypass controls not applied");

  a_aux_fifo_oob: assert property (wr_aux |=>
    {ext_rx_fifo, rmii_oob_en} == $past(bus.wdata[2:1]))
    else $error("fifo or out-of-band control not applied");

  // Reserved aux bits stay clear
  a_aux_reserved: assert property ((aux_r & ~anpfx_pkg::AUX_WR_MASK) == 16'h0000)
    else $error("reserved aux bit set");

  // Expansion status shows next page ability
  a_exp_np_able: assert property (reg_is(bus.addr, anpfx_pkg::REG_AN_EXP) |->
    bus.rdata[2])
    else $error("next page ability not reported");

  // Expansion status carries nothing but the ability bit
  a_exp_only_able: assert property (reg_is(bus.addr, anpfx_pkg::REG_AN_EXP) |->
    bus.rdata == anpfx_pkg::AN_EXP_VALUE)
    else $error("expansion status value wrong");

  // Restart returns the handshake to idle
  a_restart_idle: assert property (s_restart |=> !arb_ready && !arb_toggle)
    else $error("restart did not clear handshake");

  // A send with no page waiting leaves the toggle alone
  a_send_idle: assert property (an_page_sent && !arb_ready && !an_restart |=>
    $stable(arb_toggle))
    else $error("toggle moved with no page waiting");

  // Port ready follows the internal flag one cycle later
  a_ready_lag: assert property (##1 np_tx_ready == $past(arb_ready))
    else $error("port ready out of step");

  // Stored page moves only on a write
  a_np_hold: assert property (!wr_out_np |=> $stable(out_np_r))
    else $error("outgoing page changed without write");

  // Toggle and reserved place are never stored in the page
  a_np_rsvd: assert property ((out_np_r & ~anpfx_pkg::NP_WR_MASK) == 16'h0000)
    else $error("unwritable page bit stored");

  // A read of the page shows the live toggle
  a_np_rd_tog: assert property (reg_is(bus.addr, anpfx_pkg::REG_OUT_NP) |->
    bus.rdata[anpfx_pkg::NP_TOGGLE_BIT] == arb_toggle)
    else $error("page read toggle mismatch");

  // Partner reserved place always reads zero
  a_partner_rsvd: assert property ((partner_r & ~anpfx_pkg::PARTNER_MASK) == 16'h0000)
    else $error("partner reserved bit set");

  // Control settings move only on a write
  a_aux_hold: assert property (!wr_aux |=> $stable(aux_r))
    else $error("aux control changed without write");

  // Addresses above the bank read as zero
  a_unmapped_zero: assert property (bus.addr > anpfx_pkg::REG_AUX |->
    bus.rdata == 16'h0000)
    else $error("unmapped address not zero");

endmodule

// >>> logic/anpfx_pkg.sv
// Constants shared by the management frame engine and the register bank.
// Assumes a single core clock domain; management pins are sampled on it.
package anpfx_pkg;

  // Management register addresses
  localparam logic [4:0]  REG_AN_EXP       = 5'h06;    // Expansion status (ability bit only)
  localparam logic [4:0]  REG_OUT_NP       = 5'h07;    // Outgoing next page
  localparam logic [4:0]  REG_PARTNER_NP   = 5'h08;    // Received partner next page
  localparam logic [4:0]  REG_AUX          = 5'h10;    // 100BASE-X auxiliary control

  // Next page field positions
  localparam int          NP_MORE_BIT      = 15;       // Further next pages follow
  localparam int          NP_MSG_BIT       = 13;       // Message page
  localparam int          NP_ACK2_BIT      = 12;       // Second acknowledge
  localparam int          NP_TOGGLE_BIT    = 11;       // Toggle, read only
  localparam logic [15:0] NP_WR_MASK       = 16'hB7FF; // Bits software may write
  localparam logic [15:0] PARTNER_MASK     = 16'hBFFF; // Bits captured from the partner
  localparam logic [15:0] OUT_NP_RESET     = 16'h2001; // Message page, code field 1
  localparam logic [15:0] PARTNER_RESET    = 16'h0000;

  // Auxiliary control field positions
  localparam int          AUX_TX_DIS_BIT   = 13;
  localparam int          AUX_BYP_4B5B_BIT = 10;
  localparam int          AUX_BYP_SCR_BIT  = 9;
  localparam int          AUX_BYP_NRZI_BIT = 8;
  localparam int          AUX_BYP_ALN_BIT  = 7;
  localparam int          AUX_BLW_OFF_BIT  = 6;
  localparam int          AUX_FEF_BIT      = 5;
  localparam int          AUX_EXT_FIFO_BIT = 2;
  localparam int          AUX_OOB_BIT      = 1;
  localparam logic [15:0] AUX_WR_MASK      = 16'h27E6; // Reserved bits never stored
  localparam logic [15:0] AUX_RESET        = 16'h0000;

  // Expansion status value presented by this block
  localparam logic [15:0] AN_EXP_VALUE     = 16'h0004; // Next page ability set

  // Management frame layout
  localparam logic [5:0]  PRE_LEN          = 6'h20;    // Ones needed before a start
  localparam logic [4:0]  HDR_LAST         = 5'h0C;    // Last header bit index after first start bit
  localparam logic [4:0]  DATA_LAST        = 5'h0F;    // Last data bit index
  localparam logic [1:0]  OP_RD            = 2'h2;
  localparam logic [1:0]  OP_WR            = 2'h1;

  // Frame engine states
  typedef enum logic [2:0] {
    ANPFX_PRE = 3'b000,   // Counting preamble ones
    ANPFX_HDR = 3'b001,   // Start, opcode, addresses
    ANPFX_TA  = 3'b010,   // Turnaround
    ANPFX_RD  = 3'b011,   // Driving read data
    ANPFX_WR  = 3'b100    // Collecting write data
  } anpfx_st_t;

endpackage

// >>> logic/anpfx_regbus_if.sv
// Internal register bus between the frame engine and the register bank.
// Assumes both ends run on the core clock; strobes are one cycle wide.
`timescale 1ns/1ps
interface anpfx_regbus_if;
  logic        wr_stb;  // One-cycle write strobe
  logic [4:0]  addr;    // Register address, held through the frame
  logic [15:0] wdata;   // Write data, valid with wr_stb
  logic [15:0] rdata;   // Read data for addr, combinational

  modport frame (output wr_stb, output addr, output wdata, input rdata);
  modport regs  (input wr_stb, input addr, input wdata, output rdata);
endinterface

// >>> logic/anpfx_mdio_frame.sv
// Serial management frame engine: turns clause 22 frames into bus accesses.
// Assumes mdc and mdio_in are already synchronous to core_clk.
`timescale 1ns/1ps
module anpfx_mdio_frame (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [4:0] phy_addr,   // Strapped station address
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,  // Low while driving
  anpfx_regbus_if.frame   bus
);
  anpfx_pkg::anpfx_st_t st_r, st_nxt;   // Frame state
  logic [5:0]  cnt_r, cnt_nxt;          // Bit counter
  logic [15:0] sh_r, sh_nxt;            // Shift register
  logic        mdc_q_r;                 // Previous mdc for edge detect
  logic        rd_r, rd_nxt;            // Frame is a read
  logic        out_r, out_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic [4:0]  addr_r, addr_nxt;
  logic        wr_r, wr_nxt;
  logic        rise;
  logic [12:0] hdr;                     // Header with the newest bit

  assign rise = mdc & ~mdc_q_r;
  assign hdr  = {sh_r[11:0], mdio_in};

  // Next values, evaluated only on an mdc rising edge
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    rd_nxt   = rd_r;
    out_nxt  = out_r;
    oe_n_nxt = oe_n_r;
    addr_nxt = addr_r;
    wr_nxt   = 1'b0;
    if (rise) begin
      case (st_r)
        anpfx_pkg::ANPFX_PRE: begin
          if (mdio_in) begin
            // Saturate so long idle stretches do not wrap
            if (cnt_r != anpfx_pkg::PRE_LEN) cnt_nxt = cnt_r + 6'h01;
          end else if (cnt_r == anpfx_pkg::PRE_LEN) begin
            st_nxt  = anpfx_pkg::ANPFX_HDR;
            cnt_nxt = 6'h00;
          end else begin
            cnt_nxt = 6'h00;
          end
        end
        anpfx_pkg::ANPFX_HDR: begin
          sh_nxt  = {sh_r[14:0], mdio_in};
          cnt_nxt = cnt_r + 6'h01;
          // Thirteenth bit after the start zero completes the address fields
          if (cnt_r[4:0] == anpfx_pkg::HDR_LAST) begin
            cnt_nxt  = 6'h00;
            addr_nxt = hdr[4:0];
            rd_nxt   = (hdr[11:10] == anpfx_pkg::OP_RD);
            // Foreign address or bad start drops back to hunting
            if (hdr[12] && hdr[9:5] == phy_addr &&
                (hdr[11:10] == anpfx_pkg::OP_RD || hdr[11:10] == anpfx_pkg::OP_WR)) begin
              st_nxt = anpfx_pkg::ANPFX_TA;
            end else begin
              st_nxt = anpfx_pkg::ANPFX_PRE;
            end
          end
        end
        anpfx_pkg::ANPFX_TA: begin
          cnt_nxt = 6'h01;
          if (cnt_r == 6'h00) begin
            // First turnaround bit released; drive the zero next
            if (rd_r) begin
              oe_n_nxt = 1'b0;
              out_nxt  = 1'b0;
              sh_nxt   = bus.rdata;
            end
          end else begin
            cnt_nxt = 6'h00;
            if (rd_r) begin
              out_nxt = sh_r[15];
              sh_nxt  = {sh_r[14:0], 1'b0};
              st_nxt  = anpfx_pkg::ANPFX_RD;
            end else begin
              st_nxt  = anpfx_pkg::ANPFX_WR;
            end
          end
        end
        anpfx_pkg::ANPFX_RD: begin
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r[4:0] == anpfx_pkg::DATA_LAST) begin
            oe_n_nxt = 1'b1;
            cnt_nxt  = 6'h00;
            st_nxt   = anpfx_pkg::ANPFX_PRE;
          end else begin
            out_nxt = sh_r[15];
            sh_nxt  = {sh_r[14:0], 1'b0};
          end
        end
        anpfx_pkg::ANPFX_WR: begin
          sh_nxt  = {sh_r[14:0], mdio_in};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r[4:0] == anpfx_pkg::DATA_LAST) begin
            wr_nxt  = 1'b1;
            cnt_nxt = 6'h00;
            st_nxt  = anpfx_pkg::ANPFX_PRE;
          end
        end
        default: begin
          st_nxt   = anpfx_pkg::ANPFX_PRE;
          oe_n_nxt = 1'b1;
          cnt_nxt  = 6'h00;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= anpfx_pkg::ANPFX_PRE;
      cnt_r   <= 6'h00;
      sh_r    <= 16'h0000;
      mdc_q_r <= 1'b0;
      rd_r    <= 1'b0;
      out_r   <= 1'b0;
      oe_n_r  <= 1'b1;
      addr_r  <= 5'h00;
      wr_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      mdc_q_r <= mdc;
      rd_r    <= rd_nxt;
      out_r   <= out_nxt;
      oe_n_r  <= oe_n_nxt;
      addr_r  <= addr_nxt;
      wr_r    <= wr_nxt;
    end
  end

  assign mdio_out   = out_r;
  assign mdio_oe_n  = oe_n_r;
  assign bus.wr_stb = wr_r;
  assign bus.addr   = addr_r;
  assign bus.wdata  = sh_r;
endmodule

// >>> logic/anpfx_np_arbiter.sv
// Next page handshake: page ready flag and toggle sequencing.
// Assumes page_sent pulses once per next page that was sent and acknowledged.
`timescale 1ns/1ps
module anpfx_np_arbiter (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic load,        // Software wrote a new page
  input  wire logic page_sent,   // Page left and was acknowledged
  input  wire logic an_restart,  // Negotiation restarted
  output logic      ready,       // A page waits to be sent
  output logic      toggle       // Toggle value for the waiting page
);
  logic ready_r, ready_nxt;
  logic toggle_r, toggle_nxt;

  // Load wins over a same-cycle send so a fresh page is never lost
  always_comb begin
    ready_nxt  = ready_r;
    toggle_nxt = toggle_r;
    if (an_restart) begin
      toggle_nxt = 1'b0;
      ready_nxt  = 1'b0;
    end else if (page_sent && ready_r) begin
      toggle_nxt = ~toggle_r;
      ready_nxt  = 1'b0;
    end
    if (load) ready_nxt = 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r  <= 1'b0;
      toggle_r <= 1'b0;
    end else begin
      ready_r  <= ready_nxt;
      toggle_r <= toggle_nxt;
    end
  end

  assign ready  = ready_r;
  assign toggle = toggle_r;
endmodule

// >>> verification/anpfx_smc_model.sv
// Station management controller model that drives serial management frames.
// Assumes core_clk paces the bit timing and the data line has a pull-up.
`timescale 1ns/1ps
module anpfx_smc_model (
  input  wire logic core_clk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  output logic      mdc,
  output logic      mdio_in
);
  logic drv;  // Level this model puts on the line, 1 when released

  // Wire level: the device wins while it drives, otherwise ours or the pull-up
  assign mdio_in = mdio_oe_n ? drv : mdio_out;

  initial begin
    mdc = 1'b0;
    drv = 1'b1;
  end

  // One mdc period of eight core clocks, so each level lasts well over two.
  // The line is sampled just before the rise, where read data has settled.
  task automatic bit_cyc(input logic b, output logic s);
    @(negedge core_clk);
    mdc = 1'b0;
    drv = b;
    repeat (3) @(negedge core_clk);
    s = mdio_in;
    mdc = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask

  // Full frame: fresh preamble every time, since the device never skips it
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [15:0] hdr;
    logic        s;
    hdr = {2'b01, op, phy, ra, (op == anpfx_pkg::OP_WR) ? 2'b10 : 2'b11};
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, s);
    for (int i = 15; i >= 0; i--) bit_cyc(hdr[i], s);
    // Data MSB first; on a read the line is released to the device
    for (int i = 15; i >= 0; i--) begin
      bit_cyc((op == anpfx_pkg::OP_WR) ? wd[i] : 1'b1, s);
      rd[i] = s;
    end
    bit_cyc(1'b1, s);  // Idle period lets the register update land
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench: register accesses over the management port.
// Assumes the controller model and the register bank share core_clk.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, (e), (a)); end end
module tb;
  localparam logic [4:0] PHY = 5'h05;  // Strapped station address
  logic        core_clk, arst_n, mdc, mdio_in, mdio_out, mdio_oe_n;
  logic        an_page_sent, an_restart, an_rx_page_valid, np_tx_ready, next_page_able;
  logic [15:0] an_rx_page, np_tx_page, v;
  logic        dto, b4, scr, nrzi, aln, blw, fef, fifo, oob;
  int          n_errors, n_checks, cyc;
  logic [15:0] aux_bits [9] = '{16'h2000, 16'h0400, 16'h0200, 16'h0100, 16'h0080,
                                16'h0040, 16'h0020, 16'h0004, 16'h0002};
  wire  [15:0] aux_o = {2'b00, dto, 2'b00, b4, scr, nrzi, aln, blw, fef, 2'b00, fifo, oob, 1'b0};

  always #2.5 core_clk = ~core_clk;

  anpfx_top i_anpfx_top (.core_clk(core_clk), .arst_n(arst_n), .phy_addr(PHY), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .an_page_sent(an_page_sent), .an_restart(an_restart),
    .an_rx_page_valid(an_rx_page_valid), .an_rx_page(an_rx_page),
    .np_tx_page(np_tx_page), .np_tx_ready(np_tx_ready), .next_page_able(next_page_able),
    .differential_transmit_output_oe_n(dto), .bypass_4b5b(b4), .bypass_scrambler(scr),
    .bypass_nrzi(nrzi), .bypass_symbol_align(aln), .blw_correction_off(blw),
    .far_end_fault_signalling(fef), .ext_rx_fifo(fifo), .rmii_oob_en(oob));

  anpfx_smc_model u_smc (.core_clk(core_clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .mdc(mdc), .mdio_in(mdio_in));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    u_smc.frame(anpfx_pkg::OP_WR, PHY, ra, d, x);
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    u_smc.frame(anpfx_pkg::OP_RD, PHY, ra, 16'h0000, x);
    `CHK("read", e, x)
  endtask

  // One-cycle negotiation strobe: 0 page sent, 1 restart, 2 partner page
  task automatic strobe(input int w);
    @(negedge core_clk);
    an_page_sent = (w == 0);
    an_restart = (w == 1);
    an_rx_page_valid = (w == 2);
    @(negedge core_clk);
    {an_page_sent, an_restart, an_rx_page_valid} = 3'b000;
    repeat (3) @(negedge core_clk);
  endtask

  // Hang guard, about twice the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  initial begin
    {core_clk, arst_n, an_page_sent, an_restart, an_rx_page_valid} = 5'b00000;
    an_rx_page = 16'h0000;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    `CHK("able", 1'b1, next_page_able)
    `CHK("tx_page", 16'h2001, np_tx_page)
    rd(anpfx_pkg::REG_AN_EXP, 16'h0004);
    rd(anpfx_pkg::REG_OUT_NP, 16'h2001);
    rd(anpfx_pkg::REG_PARTNER_NP, 16'h0000);
    rd(anpfx_pkg::REG_AUX, 16'h0000);
    // Each control bit alone, seen at its output and read back
    foreach (aux_bits[k]) begin
      wr(anpfx_pkg::REG_AUX, aux_bits[k]);
      `CHK("aux", aux_bits[k]&16'hFF00, aux_o&16'hFF00)
      `CHK("aux", aux_bits[k]&16'h00FF, aux_o&16'h00FF)
      rd(anpfx_pkg::REG_AUX, aux_bits[k]);
    end
    // Ones in reserved places must not reach any control
    wr(anpfx_pkg::REG_AUX, 16'hFFFF);
    `CHK("aux", 16'h27E6, aux_o)
    // Read, modify, write back: only the transmitter is enabled again
    u_smc.frame(anpfx_pkg::OP_RD, PHY, anpfx_pkg::REG_AUX, 16'h0000, v);
    wr(anpfx_pkg::REG_AUX, v & 16'hDFFF);
    `CHK("aux", 16'h07E6, aux_o)
    // Frame for another station is ignored
    u_smc.frame(anpfx_pkg::OP_WR, PHY ^ 5'h01, anpfx_pkg::REG_AUX, 16'h0000, v);
    `CHK("aux", 16'h07E6, aux_o)
    // Outgoing page: toggle not writable, page marked ready, toggle flips
    wr(anpfx_pkg::REG_OUT_NP, 16'hFFFF);
    `CHK("tx_ready", 1'b1, np_tx_ready)
    `CHK("tx_page", 16'hB7FF, np_tx_page)
    strobe(0);
    `CHK("tx_ready", 1'b0, np_tx_ready)
    rd(anpfx_pkg::REG_OUT_NP, 16'hBFFF);
    strobe(1);
    `CHK("toggle", 1'b0, np_tx_page[11])
    wr(anpfx_pkg::REG_OUT_NP, 16'h1234);
    `CHK("tx_page", 16'h1234, np_tx_page)
    strobe(0);
    rd(anpfx_pkg::REG_OUT_NP, 16'h1A34);
    // A send with no page waiting must not move the toggle
    strobe(0);
    rd(anpfx_pkg::REG_OUT_NP, 16'h1A34);
    // Partner page captured without bit 14 and not writable
    an_rx_page = 16'hFFFF;
    strobe(2);
    rd(anpfx_pkg::REG_PARTNER_NP, 16'hBFFF);
    wr(anpfx_pkg::REG_PARTNER_NP, 16'h0000);
    rd(anpfx_pkg::REG_PARTNER_NP, 16'hBFFF);
    rd(5'h1F, 16'h0000);
    tally_and_finish;
  end
endmodule
